// File: design/asr_adc_ctrl.v
// digital control of a 12-bit successive-approximation converter: selectors, sequencer, registers
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "asr_adc_defs.vh"

// Functional notes
// - reference selector 00 external pin, 01/11 analog supply, 10 sensor reference.
// - analog-selected pins lose other functions and their pull-high resistor.
// - analog-selected pins override the port direction setting.
// - source 000/110: channel 0-7 connects a pin, 8-15 leaves input floating.
// - source 001..101 connect bandgap, sensor, amp0, amp1, line; channel ignored.
// - normal inputs sample 4 converter clocks and convert 12.
// - sensor output samples 46 converter clocks and converts 12.
// - conversion starts after start bit goes high then back low.
// - busy high during conversion, low at completion with valid result bytes.
// - result alignment over high and low bytes follows the format bit.
// - interrupt reaches processor only with global and conversion enables set.
// - converter operates only while its power enable bit is 1.
// - conversion runs autonomously in hardware without stalling the bus.
// - converter clock is system clock divided by 2**divide field.
// - every completion sets the request flag regardless of interrupt enable.
// - mode bit 0 normal, 1 low current mode.
module asr_adc_ctrl #(
  parameter RES_W = 12,
  parameter PINS  = 8
) (
  input  wire             clk_sys_i,
  input  wire             rst_i,
  input  wire [2:0]       addr_i,
  input  wire [7:0]       wr_data_i,
  input  wire             wr_i,
  input  wire             rd_i,
  output reg  [7:0]       rd_data_o,
  input  wire             comparator_i,
  input  wire [PINS-1:0]  pin_function_select_low_i,
  input  wire [PINS-1:0]  pin_function_select_high_i,
  input  wire [PINS-1:0]  port_output_dir_i,
  input  wire [PINS-1:0]  pullup_program_i,
  output reg  [PINS-1:0]  pin_analog_o,
  output reg  [PINS-1:0]  pin_output_en_o,
  output reg  [PINS-1:0]  pin_pullup_o,
  output reg              converter_power_o,
  output reg              low_current_mode_o,
  output reg              temp_sensor_enable_o,
  output reg              ref_ext_pin_o,
  output reg              ref_supply_o,
  output reg              ref_sensor_o,
  output reg  [PINS-1:0]  ext_channel_o,
  output reg  [4:0]       internal_source_o,
  output reg              sample_o,
  output reg  [RES_W-1:0] sar_code_o,
  output reg              irq_o
);

  localparam ST_IDLE    = 2'd0;
  localparam ST_SAMPLE  = 2'd1;
  localparam ST_CONVERT = 2'd2;

  function [PINS-1:0] onehot;
    input [3:0] sel;
    begin
      onehot = {PINS{1'b0}};
      if (sel < PINS) begin
        onehot[sel[2:0]] = 1'b1;
      end
    end
  endfunction

  function is_ext_source;
    input [2:0] src;
    begin
      is_ext_source = (src == `ASR_SRC_EXT_A) || (src == `ASR_SRC_EXT_B);
    end
  endfunction

  // one-hot connect of the internal signals; 000, 110 and the barred 111 connect none
  function [4:0] src_onehot;
    input [2:0] src;
    begin
      case (src)
        `ASR_SRC_BANDGAP: src_onehot = 5'h01;
        `ASR_SRC_SENSOR:  src_onehot = 5'h02;
        `ASR_SRC_AMP0:    src_onehot = 5'h04;
        `ASR_SRC_AMP1:    src_onehot = 5'h08;
        `ASR_SRC_LINE:    src_onehot = 5'h10;
        default:          src_onehot = 5'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg  [7:0]       ctrl0_reg;
  reg  [7:0]       ctrl1_reg;
  reg  [7:0]       ctrl2_reg;
  reg  [2:0]       int_reg;
  reg              start_prev_reg;
  reg              start_armed_reg;
  reg  [1:0]       state_reg;
  reg  [5:0]       cnt_reg;
  reg  [3:0]       bit_reg;
  reg  [RES_W-1:0] result_reg;
  reg              done_reg;

  wire       power_en   = ctrl0_reg[`ASR_C0_POWER];
  wire       busy       = (state_reg != ST_IDLE);
  wire [2:0] src_sel    = ctrl1_reg[`ASR_C1_SRC_HI:`ASR_C1_SRC_LO];
  wire [1:0] ref_sel    = ctrl1_reg[`ASR_C1_REF_HI:`ASR_C1_REF_LO];
  wire [3:0] chan_sel   = ctrl0_reg[`ASR_C0_CHAN_HI:`ASR_C0_CHAN_LO];
  wire       start_rise = ctrl0_reg[`ASR_C0_START] && !start_prev_reg;
  wire       start_fall = start_prev_reg && !ctrl0_reg[`ASR_C0_START];
  wire       start_go   = start_armed_reg && start_fall && power_en && !busy;
  wire       tick;
  wire       wr_ctrl0   = wr_i && (addr_i == `ASR_OFS_CTRL0);
  wire       wr_ctrl1   = wr_i && (addr_i == `ASR_OFS_CTRL1);
  wire       wr_ctrl2   = wr_i && (addr_i == `ASR_OFS_CTRL2);
  wire       wr_int     = wr_i && (addr_i == `ASR_OFS_INT);
  wire [7:0] res_high;
  wire [7:0] res_low;

  // format 0 puts the top eight bits in the high byte, format 1 right-justifies
  assign res_high = ctrl0_reg[`ASR_C0_FORMAT] ? {4'h0, result_reg[11:8]} : result_reg[11:4];
  assign res_low  = ctrl0_reg[`ASR_C0_FORMAT] ? result_reg[7:0] : {result_reg[3:0], 4'h0};

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl0_reg      <= `ASR_RST_CTRL0;
      ctrl1_reg      <= `ASR_RST_CTRL1;
      ctrl2_reg      <= `ASR_RST_CTRL2;
      int_reg        <= `ASR_RST_INT;
      start_prev_reg <= 1'b0;
      start_armed_reg <= 1'b0;
    end else begin
      start_prev_reg <= ctrl0_reg[`ASR_C0_START];
      // a pulse whose rising half fell inside a conversion is dropped whole
      if (busy || start_fall) begin
        start_armed_reg <= 1'b0;
      end else if (start_rise) begin
        start_armed_reg <= 1'b1;
      end
      if (wr_ctrl0) begin
        ctrl0_reg <= wr_data_i;
      end
      if (wr_ctrl1) begin
        ctrl1_reg <= wr_data_i;
      end
      if (wr_ctrl2) begin
        ctrl2_reg <= {wr_data_i[`ASR_C2_MODE], 5'h00, wr_data_i[`ASR_C2_RSVD:`ASR_C2_TEMP_SENSOR_ENABLE]};
      end
      if (wr_int) begin
        int_reg[`ASR_INT_CONV_IE:`ASR_INT_GLOBAL_IE] <= wr_data_i[`ASR_INT_CONV_IE:`ASR_INT_GLOBAL_IE];
      end
      // a completion in the clearing cycle wins over the clear
      if (done_reg) begin
        int_reg[`ASR_INT_FLAG] <= 1'b1;
      end else if (wr_int) begin
        int_reg[`ASR_INT_FLAG] <= wr_data_i[`ASR_INT_FLAG];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: sample phase, then one SAR bit per converter clock

  asr_clk_div u_clk_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .restart_i (start_go),
    .divide_i  (ctrl1_reg[`ASR_C1_DIV_HI:`ASR_C1_DIV_LO]),
    .tick_o    (tick)
  );

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 6'd0;
      bit_reg    <= 4'd0;
      result_reg <= {RES_W{1'b0}};
      sar_code_o <= {RES_W{1'b0}};
      sample_o   <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_go) begin
            state_reg <= ST_SAMPLE;
            sample_o  <= 1'b1;
            // sample length is fixed at start so a selector change cannot stretch it
            cnt_reg   <= (src_sel == `ASR_SRC_SENSOR) ? `ASR_SAMPLE_SENSOR : `ASR_SAMPLE_NORMAL;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (cnt_reg == 6'd1) begin
              state_reg  <= ST_CONVERT;
              sample_o   <= 1'b0;
              bit_reg    <= `ASR_CONVERT_BITS - 4'd1;
              sar_code_o <= {1'b1, {(RES_W-1){1'b0}}};
            end else begin
              cnt_reg <= cnt_reg - 6'd1;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            // keep the trial bit when the input is above the trial level
            if (!comparator_i) begin
              sar_code_o[bit_reg] <= 1'b0;
            end
            if (bit_reg == 4'd0) begin
              state_reg  <= ST_IDLE;
              result_reg <= {sar_code_o[RES_W-1:1], sar_code_o[0] & comparator_i};
              done_reg   <= 1'b1;
            end else begin
              bit_reg                       <= bit_reg - 4'd1;
              sar_code_o[bit_reg - 4'd1]    <= 1'b1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // losing power abandons a conversion; the old result stays
      if (!power_en) begin
        state_reg <= ST_IDLE;
        sample_o  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog selectors and pin control, all registered

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      converter_power_o    <= 1'b0;
      low_current_mode_o   <= 1'b0;
      temp_sensor_enable_o <= 1'b0;
      ref_ext_pin_o        <= 1'b0;
      ref_supply_o         <= 1'b0;
      ref_sensor_o         <= 1'b0;
      ext_channel_o        <= {PINS{1'b0}};
      internal_source_o    <= 5'h00;
      irq_o                <= 1'b0;
    end else begin
      converter_power_o    <= power_en;
      low_current_mode_o   <= ctrl2_reg[`ASR_C2_MODE];
      temp_sensor_enable_o <= ctrl2_reg[`ASR_C2_TEMP_SENSOR_ENABLE];
      ref_ext_pin_o        <= (ref_sel == `ASR_REF_EXT_PIN);
      ref_sensor_o         <= (ref_sel == `ASR_REF_SENSOR);
      ref_supply_o         <= ref_sel[0];
      ext_channel_o        <= is_ext_source(src_sel) ? onehot(chan_sel) : {PINS{1'b0}};
      internal_source_o    <= src_onehot(src_sel);
      irq_o                <= int_reg[`ASR_INT_FLAG] && int_reg[`ASR_INT_CONV_IE] && int_reg[`ASR_INT_GLOBAL_IE];
    end
  end

  wire [PINS-1:0] pin_is_analog;

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin
      assign pin_is_analog[gi] = ({pin_function_select_high_i[gi], pin_function_select_low_i[gi]} == `ASR_PINSEL_ANALOG);
    end
  endgenerate

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_analog_o    <= {PINS{1'b0}};
      pin_output_en_o <= {PINS{1'b0}};
      pin_pullup_o    <= {PINS{1'b0}};
    end else begin
      pin_analog_o    <= pin_is_analog;
      pin_output_en_o <= port_output_dir_i & ~pin_is_analog;
      pin_pullup_o    <= pullup_program_i & ~pin_is_analog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, zero otherwise

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ASR_OFS_CTRL0:    rd_data_o <= {ctrl0_reg[7], busy, ctrl0_reg[5:0]};
        `ASR_OFS_CTRL1:    rd_data_o <= ctrl1_reg;
        `ASR_OFS_CTRL2:    rd_data_o <= ctrl2_reg;
        `ASR_OFS_RES_HIGH: rd_data_o <= res_high;
        `ASR_OFS_RES_LOW:  rd_data_o <= res_low;
        `ASR_OFS_INT:      rd_data_o <= {5'h00, int_reg};
        default:           rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end

endmodule // asr_adc_ctrl

// File: design/asr_adc_defs.vh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ASR_ADC_DEFS_VH
`define ASR_ADC_DEFS_VH

`define ASR_OFS_CTRL0      3'h0
`define ASR_OFS_CTRL1      3'h1
`define ASR_OFS_CTRL2      3'h2
`define ASR_OFS_RES_HIGH   3'h3
`define ASR_OFS_RES_LOW    3'h4
`define ASR_OFS_INT        3'h5

// control 0 fields
`define ASR_C0_START       7
`define ASR_C0_BUSY        6
`define ASR_C0_POWER       5
`define ASR_C0_FORMAT      4
`define ASR_C0_CHAN_HI     3
`define ASR_C0_CHAN_LO     0
// control 1 fields
`define ASR_C1_SRC_HI      7
`define ASR_C1_SRC_LO      5
`define ASR_C1_REF_HI      4
`define ASR_C1_REF_LO      3
`define ASR_C1_DIV_HI      2
`define ASR_C1_DIV_LO      0
// control 2 fields
`define ASR_C2_MODE        7
`define ASR_C2_RSVD        1
`define ASR_C2_TEMP_SENSOR_ENABLE        0
// interrupt control fields
`define ASR_INT_FLAG       2
`define ASR_INT_CONV_IE    1
`define ASR_INT_GLOBAL_IE  0

`define ASR_RST_CTRL0      8'h00
`define ASR_RST_CTRL1      8'h00
`define ASR_RST_CTRL2      8'h02
`define ASR_RST_INT        3'h0

// reference selector codes
`define ASR_REF_EXT_PIN    2'b00
`define ASR_REF_SENSOR     2'b10
// source selector codes
`define ASR_SRC_EXT_A      3'b000
`define ASR_SRC_BANDGAP    3'b001
`define ASR_SRC_SENSOR     3'b010
`define ASR_SRC_AMP0       3'b011
`define ASR_SRC_AMP1       3'b100
`define ASR_SRC_LINE       3'b101
`define ASR_SRC_EXT_B      3'b110
// pin function code that turns a pin into an analog channel
`define ASR_PINSEL_ANALOG  2'b11

// converter clock periods per phase
`define ASR_SAMPLE_NORMAL  6'd4
`define ASR_SAMPLE_SENSOR  6'd46
`define ASR_CONVERT_BITS   4'd12

`endif

// File: design/asr_clk_div.v
// converter clock enable divider: one pulse every 2**divide system clocks
`timescale 1ns/10ps

module asr_clk_div #(
  parameter CNT_W = 7
) (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       restart_i,
  input  wire [2:0] divide_i,
  output wire       tick_o
);

  reg  [CNT_W-1:0] cnt_reg;
  wire [CNT_W-1:0] mask;

  // low bits that must all be ones before the tick; divide 000 ticks every cycle
  assign mask   = ~({CNT_W{1'b1}} << divide_i);
  assign tick_o = ((cnt_reg & mask) == mask);

  always @(posedge clk_sys_i) begin
    if (rst_i || restart_i) begin
      cnt_reg <= {CNT_W{1'b0}};
    end else begin
      cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // asr_clk_div

// File: test/asr_adc_ctrl_asserts.sv
// port-level assertions for the converter control block
`timescale 1ns/10ps
module asr_adc_ctrl_chk #(
  parameter RES_W = 12,
  parameter PINS  = 8
) (
  input wire             clk_sys_i,
  input wire             rst_i,
  input wire             wr_i,
  input wire [PINS-1:0]  pin_function_select_low_i,
  input wire [PINS-1:0]  pin_function_select_high_i,
  input wire [PINS-1:0]  port_output_dir_i,
  input wire [PINS-1:0]  pullup_program_i,
  input wire [PINS-1:0]  pin_analog_o,
  input wire [PINS-1:0]  pin_output_en_o,
  input wire [PINS-1:0]  pin_pullup_o,
  input wire             converter_power_o,
  input wire             ref_ext_pin_o,
  input wire             ref_supply_o,
  input wire             ref_sensor_o,
  input wire [PINS-1:0]  ext_channel_o,
  input wire [4:0]       internal_source_o,
  input wire             sample_o,
  input wire [RES_W-1:0] sar_code_o
);
  // outputs read 0 for two edges after reset, so checks wait for this
  reg  [1:0]      live_reg;
  wire [PINS-1:0] an = pin_function_select_low_i & pin_function_select_high_i;
  always @(posedge clk_sys_i) live_reg <= {live_reg[0], !rst_i};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_pin_analog: assert property (&live_reg |-> pin_analog_o == $past(an))
    else $error("pin analog select wrong");
  a_pullup_cut: assert property (&live_reg |-> pin_pullup_o == $past(pullup_program_i & ~an))
    else $error("pull-high not cut");
  a_dir_override: assert property (&live_reg |-> pin_output_en_o == $past(port_output_dir_i & ~an))
    else $error("direction not overridden");
  a_ref_onehot: assert property (&live_reg |-> $onehot({ref_ext_pin_o, ref_supply_o, ref_sensor_o}))
    else $error("reference not one-hot");
  a_src_exclusive: assert property (!(|ext_channel_o && |internal_source_o) && $onehot0(ext_channel_o)
    && $onehot0(internal_source_o))
    else $error("two sources connected");
  a_sample_min: assert property ($rose(sample_o) |-> sample_o[*4])
    else $error("sample phase too short");
  a_sensor_sample: assert property ($rose(sample_o) && internal_source_o[1] |-> sample_o[*8])
    else $error("sensor sample too short");
  a_first_trial: assert property ($fell(sample_o) && converter_power_o |-> sar_code_o == {1'b1, {RES_W-1{1'b0}}})
    else $error("first trial code wrong");
  a_power_gate: assert property (!converter_power_o ##1 !converter_power_o |-> !sample_o)
    else $error("sampling while powered off");
  a_start_cause: assert property ($rose(sample_o) |-> $past(wr_i, 2) || $past(wr_i, 3) || $past(wr_i, 4))
    else $error("sampling without start write");
  c_sample: cover property ($rose(sample_o));
  c_done: cover property ($fell(sample_o));
  c_sensor: cover property (sample_o && internal_source_o[1]);
endmodule // asr_adc_ctrl_chk
bind asr_adc_ctrl asr_adc_ctrl_chk #(.RES_W(RES_W), .PINS(PINS)) u_chk (.clk_sys_i, .rst_i, .wr_i,
  .pin_function_select_low_i, .pin_function_select_high_i, .port_output_dir_i, .pullup_program_i,
  .pin_analog_o, .pin_output_en_o, .pin_pullup_o, .converter_power_o, .ref_ext_pin_o, .ref_supply_o,
  .ref_sensor_o, .ext_channel_o, .internal_source_o, .sample_o, .sar_code_o);

// File: test/asr_analog_model.sv
// comparator stand-in for the analog sources behind the converter
`timescale 1ns/10ps
module asr_analog_model (
  input  wire        clk_sys_i,
  input  wire [7:0]  pins_i,
  input  wire [4:0]  src_i,
  input  wire [11:0] code_i,
  output wire        cmp_o
);
  reg         flt_reg = 1'b0;
  // each source gets its own level so a wrong route shows in the result
  wire [11:0] level = (|src_i) ? (12'ha00 ^ {7'h00, src_i}) : (12'h5a0 ^ {4'h0, pins_i});
  // nothing connected: the input floats, so the comparator wanders
  always @(posedge clk_sys_i) flt_reg <= ~flt_reg;
  assign cmp_o = (|{src_i, pins_i}) ? (level >= code_i) : flt_reg;
endmodule // asr_analog_model

// File: test/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module tb;
  reg         clk_sys_i = 1'b0;
  reg         rst_i     = 1'b1;
  reg  [2:0]  addr      = 3'h0;
  reg  [7:0]  wdat      = 8'h00;
  reg         wr        = 1'b0;
  reg         rd        = 1'b0;
  reg  [7:0]  fs_lo     = 8'h00;
  reg  [7:0]  fs_hi     = 8'h00;
  reg  [7:0]  dir       = 8'h00;
  reg  [7:0]  pu        = 8'h00;
  wire [7:0]  rdat, p_an, p_oe, p_pu, ext;
  wire [4:0]  isrc;
  wire [11:0] code;
  wire        cmp, pwr, lcm, temp_sensor_enable, r_ext, r_sup, r_sen, smp, irq;
  integer     n_fail    = 0;
  integer     checked   = 0;
  integer     i;
  reg  [7:0]  v;
  always #5 clk_sys_i = ~clk_sys_i;
  asr_adc_ctrl dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rdat), .comparator_i(cmp), .pin_function_select_low_i(fs_lo),
    .pin_function_select_high_i(fs_hi), .port_output_dir_i(dir), .pullup_program_i(pu),
    .pin_analog_o(p_an), .pin_output_en_o(p_oe), .pin_pullup_o(p_pu), .converter_power_o(pwr),
    .low_current_mode_o(lcm), .temp_sensor_enable_o(temp_sensor_enable), .ref_ext_pin_o(r_ext), .ref_supply_o(r_sup),
    .ref_sensor_o(r_sen), .ext_channel_o(ext), .internal_source_o(isrc), .sample_o(smp),
    .sar_code_o(code), .irq_o(irq));
  asr_analog_model model (.clk_sys_i(clk_sys_i), .pins_i(ext), .src_i(isrc), .code_i(code), .cmp_o(cmp));
  ////////////////////////////////////////////////////////////////
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [127:0] what, input [15:0] exp, input [15:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task wr_reg(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk_sys_i);
      addr <= a; wdat <= d; wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [2:0] a);
    begin
      @(posedge clk_sys_i);
      addr <= a; rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1 v = rdat;
    end
  endtask
  task settle;
    begin
      repeat (3) @(negedge clk_sys_i);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_regs;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        rd_reg(i[2:0]);
        chk("reset value", (i == 2) ? 16'h02 : 16'h00, {8'h00, v});
      end
      wr_reg(3'h2, 8'hff); rd_reg(3'h2); chk("ctrl2", 16'h83, {8'h00, v});
      chk("mode temp_sensor_enable", 16'h3, {lcm, temp_sensor_enable});
      wr_reg(3'h6, 8'hff); rd_reg(3'h6); chk("unmapped", 16'h00, {8'h00, v});
      wr_reg(3'h0, 8'h4a); rd_reg(3'h0); chk("busy ro", 16'h0a, {8'h00, v});
      wr_reg(3'h2, 8'h03);
    end
  endtask
  task t_ref;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr_reg(3'h1, {3'h0, i[1:0], 3'h0}); settle;
        chk("ref", (i == 0) ? 16'h4 : (i == 2) ? 16'h1 : 16'h2, {r_ext, r_sup, r_sen});
      end
    end
  endtask
  task t_src;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        wr_reg(3'h0, 8'h09); wr_reg(3'h1, {i[2:0], 5'h08}); settle;
        chk("src park", (i == 0 || i == 6) ? 16'h0 : {8'h00, 5'h01 << (i - 1)}, {ext, isrc});
        wr_reg(3'h0, 8'h03); settle;
        chk("src pin", (i == 0 || i == 6) ? 16'h100 : {8'h00, 5'h01 << (i - 1)}, {ext, isrc});
      end
    end
  endtask
  task t_pins;
    begin
      @(posedge clk_sys_i);
      fs_lo <= 8'h0f; fs_hi <= 8'h3c; dir <= 8'hff; pu <= 8'h55; settle;
      chk("analog", 16'h0c, {8'h00, p_an});
      chk("pullup", 16'h51, {8'h00, p_pu});
      chk("out en", 16'hf3, {8'h00, p_oe});
    end
  endtask
  // full conversion: sample length, result bytes, no restart from a start pulse while busy
  task conv(input [2:0] s, input [3:0] ch, input f, input [2:0] d, input integer ns, input [11:0] lv);
    integer k, n;
    reg     seen;
    begin
      wr_reg(3'h1, {3'h0, 2'b01, d});
      wr_reg(3'h0, {3'b001, f, ch});
      wr_reg(3'h1, {s, 2'b01, d});
      wr_reg(3'h0, {3'b101, f, ch}); wr_reg(3'h0, {3'b001, f, ch});
      n = 0;
      for (k = 0; k < 20 && smp !== 1'b1; k = k + 1) @(negedge clk_sys_i);
      while (smp === 1'b1 && n < 400) begin n = n + 1; @(negedge clk_sys_i); end
      chk("sample len", ns, (n + (1 << d) - 1) >> d);
      chk("power", 16'h1, {15'h0, pwr});
      wr_reg(3'h0, {3'b101, f, ch}); wr_reg(3'h0, {3'b001, f, ch});
      k = 0; v = 8'h40;
      while (v[6] !== 1'b0 && k < 400) begin rd_reg(3'h0); k = k + 1; end
      chk("busy timeout", 16'h0, {15'h0, v[6]});
      rd_reg(3'h3); chk("res high", f ? {12'h0, lv[11:8]} : {8'h0, lv[11:4]}, {8'h00, v});
      rd_reg(3'h4); chk("res low", f ? {8'h0, lv[7:0]} : {8'h0, lv[3:0], 4'h0}, {8'h00, v});
      seen = 1'b0;
      for (k = 0; k < 20; k = k + 1) begin @(negedge clk_sys_i); seen = seen | smp; end
      chk("restart", 16'h0, {15'h0, seen});
    end
  endtask
  task t_conv_irq;
    begin
      wr_reg(3'h5, 8'h03); conv(3'h0, 4'h3, 1'b0, 3'h0, 4, 12'h5a8);
      chk("irq on", 16'h1, {15'h0, irq});
      rd_reg(3'h5); chk("flag", 16'h07, {8'h00, v});
      wr_reg(3'h5, 8'h03); settle; chk("irq clr", 16'h0, {15'h0, irq});
    end
  endtask
  task t_conv_sensor;
    begin
      wr_reg(3'h2, 8'h03); wr_reg(3'h5, 8'h01);
      conv(3'h2, 4'h8, 1'b1, 3'h0, 46, 12'ha02);
      chk("irq gated", 16'h0, {15'h0, irq});
      rd_reg(3'h5); chk("flag", 16'h05, {8'h00, v});
    end
  endtask
  task t_conv_div;
    begin
      wr_reg(3'h5, 8'h02); conv(3'h5, 4'hf, 1'b0, 3'h2, 4, 12'ha10);
      chk("irq gated", 16'h0, {15'h0, irq});
    end
  endtask
  task t_power_off;
    reg seen;
    begin
      wr_reg(3'h0, 8'h83); wr_reg(3'h0, 8'h03); seen = 1'b0;
      for (i = 0; i < 30; i = i + 1) begin @(negedge clk_sys_i); seen = seen | smp; end
      chk("no power", 16'h0, {15'h0, seen});
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_regs;
    t_ref;
    t_src;
    t_pins;
    t_conv_irq;
    t_conv_sensor;
    t_conv_div;
    t_power_off;
    close_out;
  end
endmodule // tb
